// [design/pcc_pkg.sv]
// constants for the power control command register bank
package pcc_pkg;

	// command codes of the register bank
	localparam logic [7:0] PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN = 8'h01;
	localparam logic [7:0] PCC_CMD_ON_OFF_CONFIG = 8'h02;
	localparam logic [7:0] PCC_CMD_VOUT_OV_RESP = 8'h41;
	localparam logic [7:0] PCC_CMD_SEC_ONOFF_CFG = 8'h6D;
	localparam logic [7:0] PCC_CMD_POWER_GOOD_OUTPUT_POL = 8'h6E;

	// output_on_off_and_margin layout
	localparam int PCC_OP_ON_BIT = 7;
	localparam int PCC_OP_SRC_LSB = 4;
	localparam logic [7:0] PCC_OP_RESET = 8'h80;
	localparam logic PCC_OP_ON_RESET = 1'b1;

	// setpoint source codes
	localparam logic [1:0] PCC_SRC_NOMINAL = 2'h0;
	localparam logic [1:0] PCC_SRC_MARGIN_LOW = 2'h1;
	localparam logic [1:0] PCC_SRC_MARGIN_HIGH = 2'h2;
	localparam logic [1:0] PCC_SRC_BAD = 2'h3;

	// power_up_gating_config: bit4 and bit3 fixed one, bit2 fixed zero
	localparam int PCC_ONOFF_CTRL_OP_BIT = 4;
	localparam int PCC_ONOFF_OP_BIT = 3;
	localparam int PCC_ONOFF_PIN_ONLY_BIT = 2;
	localparam logic [7:0] PCC_ONOFF_VALUE = 8'h18;

	// output_overvoltage_response layout
	localparam int PCC_OV_RESP_LSB = 6;
	localparam int PCC_OV_RETRY_LSB = 3;
	localparam logic [1:0] PCC_OV_RESP_SHUTDOWN = 2'h2;
	localparam logic [2:0] PCC_RETRY_LATCH = 3'h0;
	localparam logic [2:0] PCC_RETRY_CONT = 3'h7;
	localparam logic [7:0] PCC_OV_RESET = 8'hB8;

	// secondary_onoff_pin_config and power_good_polarity
	localparam int PCC_SEC_EN_BIT = 0;
	localparam int PCC_SEC_POS_BIT = 1;
	localparam int PCC_PG_POS_BIT = 0;
	localparam logic [7:0] PCC_SEC_RESET = 8'h00;
	localparam logic [7:0] PCC_PG_RESET = 8'h00;

	// answer to an unknown command code
	localparam logic [7:0] PCC_RD_UNMAPPED = 8'h00;

	// restart hold-off between retries
	localparam int PCC_CLK_MHZ = 200;
	localparam int PCC_RETRY_DELAY_US = 10;
	localparam int PCC_RETRY_CYCLES = PCC_RETRY_DELAY_US * PCC_CLK_MHZ;

	// fault response states
	typedef enum logic [1:0] {
		PCC_ST_RUN,
		PCC_ST_LATCHED,
		PCC_ST_RETRY_WAIT
	} pcc_state_t;

endpackage : pcc_pkg

// [design/pcc_sync.sv]
// two-flop synchroniser, one stage pair per bit
`timescale 1ns/1ps
module pcc_sync #(
	parameter int WIDTH = 4
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// asynchronous levels in, synchronous levels out
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	initial
	begin
		if (WIDTH < 1)
			$error("pcc_sync: WIDTH must be at least 1");
	end

	for (genvar i = 0; i < WIDTH; i++)
	begin : g_bit
		logic meta_ff;
		logic hold_ff;
		always_ff @(posedge sys_clk or negedge arst_n)
		begin
			if (!arst_n)
			begin
				meta_ff <= 1'b0;
				hold_ff <= 1'b0;
			end
			else
			begin
				meta_ff <= async_in[i];
				hold_ff <= meta_ff;
			end
		end
		assign sync_out[i] = hold_ff;
	end

endmodule : pcc_sync

// [design/pcc_regs.sv]
// on/off and fault response command registers of the power converter
`timescale 1ns/1ps
module pcc_regs
	import pcc_pkg::*;
#(
	parameter int RETRY_CYCLES = PCC_RETRY_CYCLES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// command port from the bus engine
	input wire logic [7:0] cmd_code,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_wr_data,
	input wire logic cmd_rd,
	output logic [7:0] cmd_rd_data,
	output logic cmd_rd_valid,
	output logic cmd_unmapped,
	// pins and analog status, asynchronous
	input wire logic control_pin,
	input wire logic secondary_onoff_pin,
	input wire logic ov_fault_raw,
	input wire logic power_good_raw,
	// converter controls
	output logic output_enable,
	output logic [1:0] setpoint_sel,
	output logic power_good_output,
	output logic ov_shutdown
);

	localparam int CW = $clog2(RETRY_CYCLES + 1);

	initial
	begin
		if (RETRY_CYCLES < 1)
			$error("pcc_regs: RETRY_CYCLES must be at least 1");
	end

	// synchronised inputs
	logic [3:0] pins_sync;
	logic control_s;
	logic secondary_s;
	logic ov_fault_s;
	logic power_good_s;

	pcc_sync #(
		.WIDTH(4)
	) u_sync (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.async_in({power_good_raw, ov_fault_raw, secondary_onoff_pin,
			control_pin}),
		.sync_out(pins_sync)
	);

	assign control_s = pins_sync[0];
	assign secondary_s = pins_sync[1];
	assign ov_fault_s = pins_sync[2];
	assign power_good_s = pins_sync[3];

	// register state
	logic op_on_ff;
	logic nxt_op_on;
	logic [1:0] op_src_ff;
	logic [1:0] nxt_op_src;
	logic [2:0] ov_retry_ff;
	logic [2:0] nxt_ov_retry;
	logic [7:0] sec_cfg_ff;
	logic [7:0] nxt_sec_cfg;
	logic [7:0] pg_pol_ff;
	logic [7:0] nxt_pg_pol;
	logic [7:0] op_byte;
	logic [7:0] ov_byte;
	logic [7:0] onoff_byte;
	logic op_write;

	assign op_write = cmd_wr && (cmd_code == PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN);

	// readback images
	always_comb
	begin
		op_byte = 8'h00;
		op_byte[PCC_OP_ON_BIT] = op_on_ff;
		op_byte[PCC_OP_SRC_LSB +: 2] = op_src_ff;
		ov_byte = 8'h00;
		ov_byte[PCC_OV_RESP_LSB +: 2] = PCC_OV_RESP_SHUTDOWN;
		ov_byte[PCC_OV_RETRY_LSB +: 3] = ov_retry_ff;
		onoff_byte = PCC_ONOFF_VALUE;
	end

	always_comb
	begin
		nxt_op_on = op_on_ff;
		nxt_op_src = op_src_ff;
		nxt_ov_retry = ov_retry_ff;
		nxt_sec_cfg = sec_cfg_ff;
		nxt_pg_pol = pg_pol_ff;
		if (cmd_wr)
		begin
			case (cmd_code)
				PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN:
				begin
					nxt_op_on = cmd_wr_data[PCC_OP_ON_BIT];
					if (cmd_wr_data[PCC_OP_SRC_LSB +: 2] != PCC_SRC_BAD)
						nxt_op_src = cmd_wr_data[PCC_OP_SRC_LSB +: 2];
				end
				PCC_CMD_VOUT_OV_RESP:
				begin
					if (cmd_wr_data[PCC_OV_RETRY_LSB +: 3] == PCC_RETRY_LATCH ||
						cmd_wr_data[PCC_OV_RETRY_LSB +: 3] == PCC_RETRY_CONT)
						nxt_ov_retry = cmd_wr_data[PCC_OV_RETRY_LSB +: 3];
				end
				PCC_CMD_SEC_ONOFF_CFG:
					nxt_sec_cfg = cmd_wr_data;
				PCC_CMD_POWER_GOOD_OUTPUT_POL:
					nxt_pg_pol = cmd_wr_data;
				default:
					nxt_sec_cfg = sec_cfg_ff;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			op_on_ff <= PCC_OP_ON_RESET;
			op_src_ff <= PCC_OP_RESET[PCC_OP_SRC_LSB +: 2];
			ov_retry_ff <= PCC_OV_RESET[PCC_OV_RETRY_LSB +: 3];
			sec_cfg_ff <= PCC_SEC_RESET;
			pg_pol_ff <= PCC_PG_RESET;
		end
		else
		begin
			op_on_ff <= nxt_op_on;
			op_src_ff <= nxt_op_src;
			ov_retry_ff <= nxt_ov_retry;
			sec_cfg_ff <= nxt_sec_cfg;
			pg_pol_ff <= nxt_pg_pol;
		end
	end

	// read answer, one cycle after the strobe
	logic [7:0] rd_data_ff;
	logic [7:0] nxt_rd_data;
	logic rd_valid_ff;
	logic nxt_rd_valid;
	logic unmapped_ff;
	logic nxt_unmapped;
	logic code_known;

	always_comb
	begin
		code_known = 1'b1;
		nxt_rd_data = PCC_RD_UNMAPPED;
		case (cmd_code)
			PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN: nxt_rd_data = op_byte;
			PCC_CMD_ON_OFF_CONFIG: nxt_rd_data = onoff_byte;
			PCC_CMD_VOUT_OV_RESP: nxt_rd_data = ov_byte;
			PCC_CMD_SEC_ONOFF_CFG: nxt_rd_data = sec_cfg_ff;
			PCC_CMD_POWER_GOOD_OUTPUT_POL: nxt_rd_data = pg_pol_ff;
			default: code_known = 1'b0;
		endcase
		if (!cmd_rd)
			nxt_rd_data = rd_data_ff;
		nxt_rd_valid = cmd_rd;
		nxt_unmapped = (cmd_rd || cmd_wr) && !code_known;
	end

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_data_ff <= PCC_RD_UNMAPPED;
			rd_valid_ff <= 1'b0;
			unmapped_ff <= 1'b0;
		end
		else
		begin
			rd_data_ff <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
			unmapped_ff <= nxt_unmapped;
		end
	end

	assign cmd_rd_data = rd_data_ff;
	assign cmd_rd_valid = rd_valid_ff;
	assign cmd_unmapped = unmapped_ff;

	// overvoltage response state
	pcc_state_t state_ff;
	pcc_state_t nxt_state;
	logic [CW-1:0] retry_cnt_ff;
	logic [CW-1:0] nxt_retry_cnt;
	logic out_en_ff;
	logic nxt_out_en;

	always_comb
	begin
		nxt_state = state_ff;
		nxt_retry_cnt = retry_cnt_ff;
		case (state_ff)
			PCC_ST_RUN:
			begin
				if (ov_fault_s && out_en_ff)
				begin
					if (ov_retry_ff == PCC_RETRY_CONT)
					begin
						nxt_state = PCC_ST_RETRY_WAIT;
						nxt_retry_cnt = CW'(RETRY_CYCLES);
					end
					else
						nxt_state = PCC_ST_LATCHED;
				end
			end
			PCC_ST_LATCHED:
			begin
				if (op_write)
					nxt_state = PCC_ST_RUN;
			end
			PCC_ST_RETRY_WAIT:
			begin
				if (!op_on_ff || retry_cnt_ff == '0)
					nxt_state = PCC_ST_RUN;
				else
					nxt_retry_cnt = retry_cnt_ff - CW'(1);
			end
			default:
				nxt_state = PCC_ST_RUN;
		endcase
	end

	// secondary pin qualification and output enable
	logic sec_ok;
	logic pg_out;
	logic [1:0] nxt_setpoint;
	logic nxt_pg;
	logic nxt_ov_shut;

	always_comb
	begin
		if (!sec_cfg_ff[PCC_SEC_EN_BIT])
			sec_ok = 1'b1;
		else if (sec_cfg_ff[PCC_SEC_POS_BIT])
			sec_ok = secondary_s;
		else
			sec_ok = !secondary_s;
		// power-up waits for both the pin and the command
		nxt_out_en = op_on_ff && control_s && sec_ok &&
			(nxt_state == PCC_ST_RUN);
		pg_out = pg_pol_ff[PCC_PG_POS_BIT] ? power_good_s : !power_good_s;
		nxt_pg = pg_out;
		nxt_setpoint = op_src_ff;
		nxt_ov_shut = (nxt_state != PCC_ST_RUN);
	end

	logic [1:0] setpoint_ff;
	logic pg_ff;
	logic ov_shut_ff;

	always_ff @(posedge sys_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff <= PCC_ST_RUN;
			retry_cnt_ff <= '0;
			out_en_ff <= 1'b0;
			setpoint_ff <= PCC_SRC_NOMINAL;
			pg_ff <= 1'b1;
			ov_shut_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			retry_cnt_ff <= nxt_retry_cnt;
			out_en_ff <= nxt_out_en;
			setpoint_ff <= nxt_setpoint;
			pg_ff <= nxt_pg;
			ov_shut_ff <= nxt_ov_shut;
		end
	end

	assign output_enable = out_en_ff;
	assign setpoint_sel = setpoint_ff;
	assign power_good_output = pg_ff;
	assign ov_shutdown = ov_shut_ff;

endmodule : pcc_regs

// [tb/pcc_host_model.sv]
// host model driving the command port
`timescale 1ns/1ps
module pcc_host_model (
	// clock
	input wire logic sys_clk,
	// command port
	output logic [7:0] cmd_code,
	output logic cmd_wr,
	output logic [7:0] cmd_wr_data,
	output logic cmd_rd,
	input wire logic [7:0] cmd_rd_data
);
	initial
	begin
		cmd_code = 8'h00;
		cmd_wr = 1'b0;
		cmd_wr_data = 8'h00;
		cmd_rd = 1'b0;
	end
	task wr(input logic [7:0] c, input logic [7:0] v);
		@(posedge sys_clk);
		#1;
		cmd_code = c;
		cmd_wr_data = v;
		cmd_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		cmd_wr = 1'b0;
		// released data does not keep its value
		cmd_wr_data = ~v;
	endtask : wr
	task rd(input logic [7:0] c, output logic [7:0] v);
		@(posedge sys_clk);
		#1;
		cmd_code = c;
		cmd_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		cmd_rd = 1'b0;
		v = cmd_rd_data;
	endtask : rd
endmodule : pcc_host_model

// [tb/pcc_regs_assertions.sv]
// concurrent checks on the command register ports
`timescale 1ns/1ps
module pcc_regs_checker
	import pcc_pkg::*;
#(
	parameter int RETRY_CYCLES = PCC_RETRY_CYCLES
) (
	// clock, reset
	input wire logic sys_clk,
	input wire logic arst_n,
	// command port
	input wire logic [7:0] cmd_code,
	input wire logic cmd_wr,
	input wire logic [7:0] cmd_wr_data,
	input wire logic cmd_rd,
	input wire logic [7:0] cmd_rd_data,
	input wire logic cmd_rd_valid,
	input wire logic cmd_unmapped,
	// pins and controls
	input wire logic control_pin,
	input wire logic secondary_onoff_pin,
	input wire logic ov_fault_raw,
	input wire logic power_good_raw,
	input wire logic output_enable,
	input wire logic [1:0] setpoint_sel,
	input wire logic power_good_output,
	input wire logic ov_shutdown
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!arst_n);
	logic rd_known;
	assign rd_known = cmd_code inside {PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN, PCC_CMD_ON_OFF_CONFIG,
		PCC_CMD_VOUT_OV_RESP, PCC_CMD_SEC_ONOFF_CFG, PCC_CMD_POWER_GOOD_OUTPUT_POL};
	a_rd_valid_pulse: assert property (cmd_rd_valid == $past(cmd_rd))
		else $error("read valid not one cycle after read");
	a_onoff_fixed_read: assert property (
		cmd_rd && cmd_code == PCC_CMD_ON_OFF_CONFIG |=>
		cmd_rd_data == PCC_ONOFF_VALUE) else $error("gating config wrong");
	a_op_unused_zero: assert property (
		cmd_rd && cmd_code == PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN |=>
		(cmd_rd_data & 8'h4F) == 8'h00) else $error("unused op bits set");
	a_ov_field_fixed: assert property (
		cmd_rd && cmd_code == PCC_CMD_VOUT_OV_RESP |=>
		(cmd_rd_data & 8'hC7) == 8'h80) else $error("ov response field wrong");
	a_unmapped_read: assert property (cmd_rd && !rd_known |=>
		cmd_unmapped && cmd_rd_data == PCC_RD_UNMAPPED)
		else $error("unknown code read wrong");
	a_src_code_legal: assert property (
		setpoint_sel != PCC_SRC_BAD) else $error("unsupported source code");
	a_off_cmd_drops: assert property (
		cmd_wr && cmd_code == PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN && !cmd_wr_data[7] |->
		##[1:2] !output_enable) else $error("off command ignored");
	a_shut_keeps_off: assert property (
		ov_shutdown |-> !output_enable) else $error("output on in shutdown");
	a_fault_shuts: assert property (
		output_enable && $rose(ov_fault_raw) |-> ##[1:4] ov_shutdown)
		else $error("fault did not shut down");
	c_shutdown: cover property (ov_shutdown);
	c_unmapped: cover property (cmd_unmapped);
	c_margin_high: cover property (setpoint_sel == PCC_SRC_MARGIN_HIGH);
endmodule : pcc_regs_checker

// [tb/power_control_command_registers_test.sv]
// self-checking bench for the command register bank
`timescale 1ns/1ps
module power_control_command_registers_test;
	import pcc_pkg::*;
	logic sys_clk, arst_n, control_pin, secondary_onoff_pin;
	logic ov_fault_raw, power_good_raw, cmd_wr, cmd_rd, cmd_rd_valid;
	logic cmd_unmapped, output_enable, power_good_output, ov_shutdown;
	logic [7:0] cmd_code, cmd_wr_data, cmd_rd_data, d;
	logic [1:0] setpoint_sel;
	logic [7:0] opw [4] = '{8'h90, 8'hA0, 8'hB0, 8'hFF};
	logic [7:0] opr [4] = '{8'h90, 8'hA0, 8'hA0, 8'hA0};
	int err_total = 0;
	int comparisons = 0;
	int cyc = 0;
	pcc_host_model host_u (.sys_clk, .cmd_code, .cmd_wr, .cmd_wr_data,
		.cmd_rd, .cmd_rd_data);
	pcc_regs #(.RETRY_CYCLES(4)) dut_u (.sys_clk, .arst_n, .cmd_code,
		.cmd_wr, .cmd_wr_data, .cmd_rd, .cmd_rd_data, .cmd_rd_valid,
		.cmd_unmapped, .control_pin, .secondary_onoff_pin, .ov_fault_raw,
		.power_good_raw, .output_enable, .setpoint_sel, .power_good_output,
		.ov_shutdown);
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task rdc(input logic [7:0] c, input logic [7:0] e);
		host_u.rd(c, d);
		chk("read", e, d);
	endtask : rdc
	task wt(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : wt
	task finish_test;
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : finish_test
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			err_total++;
			finish_test;
		end
	end
	initial
	begin
		arst_n = 1'b0;
		control_pin = 1'b1;
		secondary_onoff_pin = 1'b1;
		ov_fault_raw = 1'b0;
		power_good_raw = 1'b1;
		wt(5);
		arst_n = 1'b1;
		wt(4);
		rdc(PCC_CMD_SEC_ONOFF_CFG, 8'h00);
		rdc(PCC_CMD_POWER_GOOD_OUTPUT_POL, 8'h00);
		rdc(PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN, 8'h80);
		rdc(PCC_CMD_ON_OFF_CONFIG, 8'h18);
		rdc(PCC_CMD_VOUT_OV_RESP, 8'hB8);
		chk("oe", 8'h01, {7'h00, output_enable});
		chk("pg", 8'h00, {7'h00, power_good_output});
		rdc(8'h55, 8'h00);
		chk("unmapped", 8'h01, {7'h00, cmd_unmapped});
		host_u.wr(PCC_CMD_SEC_ONOFF_CFG, 8'h01);
		wt(4);
		chk("oe", 8'h00, {7'h00, output_enable});
		host_u.wr(PCC_CMD_SEC_ONOFF_CFG, 8'h03);
		wt(4);
		chk("oe", 8'h01, {7'h00, output_enable});
		rdc(PCC_CMD_SEC_ONOFF_CFG, 8'h03);
		host_u.wr(PCC_CMD_POWER_GOOD_OUTPUT_POL, 8'h01);
		wt(4);
		chk("pg", 8'h01, {7'h00, power_good_output});
		rdc(PCC_CMD_POWER_GOOD_OUTPUT_POL, 8'h01);
		for (int i = 0; i < 4; i++)
		begin
			host_u.wr(PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN, opw[i]);
			wt(1);
			chk("sel", {6'h00, opr[i][5:4]}, {6'h00, setpoint_sel});
			rdc(PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN, opr[i]);
		end
		host_u.wr(PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN, 8'h00);
		wt(1);
		chk("oe", 8'h00, {7'h00, output_enable});
		host_u.wr(PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN, 8'h80);
		host_u.wr(PCC_CMD_ON_OFF_CONFIG, 8'h00);
		rdc(PCC_CMD_ON_OFF_CONFIG, 8'h18);
		control_pin = 1'b0;
		wt(4);
		chk("oe", 8'h00, {7'h00, output_enable});
		control_pin = 1'b1;
		host_u.wr(PCC_CMD_VOUT_OV_RESP, 8'h80);
		rdc(PCC_CMD_VOUT_OV_RESP, 8'h80);
		ov_fault_raw = 1'b1;
		wt(4);
		chk("shut", 8'h01, {7'h00, ov_shutdown});
		ov_fault_raw = 1'b0;
		wt(20);
		chk("oe", 8'h00, {7'h00, output_enable});
		host_u.wr(PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN, 8'h80);
		wt(3);
		chk("oe", 8'h01, {7'h00, output_enable});
		host_u.wr(PCC_CMD_VOUT_OV_RESP, 8'h48);
		rdc(PCC_CMD_VOUT_OV_RESP, 8'h80);
		host_u.wr(PCC_CMD_VOUT_OV_RESP, 8'hFF);
		rdc(PCC_CMD_VOUT_OV_RESP, 8'hB8);
		ov_fault_raw = 1'b1;
		wt(4);
		chk("shut", 8'h01, {7'h00, ov_shutdown});
		ov_fault_raw = 1'b0;
		wt(12);
		chk("oe", 8'h01, {7'h00, output_enable});
		arst_n = 1'b0;
		wt(2);
		arst_n = 1'b1;
		wt(4);
		chk("oe", 8'h01, {7'h00, output_enable});
		rdc(PCC_CMD_OUTPUT_ON_OFF_AND_MARGIN, 8'h80);
		rdc(PCC_CMD_VOUT_OV_RESP, 8'hB8);
		finish_test;
	end
endmodule : power_control_command_registers_test
bind pcc_regs pcc_regs_checker #(.RETRY_CYCLES(RETRY_CYCLES)) chk_u (
	.sys_clk, .arst_n, .cmd_code, .cmd_wr, .cmd_wr_data, .cmd_rd,
	.cmd_rd_data, .cmd_rd_valid, .cmd_unmapped, .control_pin,
	.secondary_onoff_pin, .ov_fault_raw, .power_good_raw, .output_enable,
	.setpoint_sel, .power_good_output, .ov_shutdown);
